// >>> core/fidc_pkg.sv
package fidc_pkg;
	// opcodes
	localparam logic [7:0] OP_QUAD_IDENT = 8'hAF;
	localparam logic [7:0] OP_PARAM = 8'h5A;
	localparam logic [7:0] OP_UNIQUE = 8'h4C;
	localparam logic [7:0] OP_STATUS1 = 8'h05;
	localparam logic [7:0] OP_STATUS2 = 8'h07;
	localparam logic [7:0] OP_CONFIG1 = 8'h35;
	localparam logic [7:0] OP_REG_WRITE = 8'h01;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	////////////////////////////////////////////////////////////////
	// status1 / config1 field positions
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 4;
	localparam int ST_EERR = 5;
	localparam int ST_PERR = 6;
	localparam int ST_LOCK = 7;
	localparam int CF_QUAD = 1;
	localparam logic [7:0] ST1_RST = 8'h00;
	localparam logic [7:0] ST1NV_RST = 8'h00;
	localparam logic [7:0] CF1_RST = 8'h00;
	////////////////////////////////////////////////////////////////
	// frame lengths in serial clocks; register write lengths in data bits
	localparam logic [5:0] OP_CLKS_SINGLE = 6'h08;
	localparam logic [5:0] OP_CLKS_QUAD = 6'h02;
	localparam logic [5:0] ADDR_CLKS_SINGLE = 6'h18;
	localparam logic [5:0] ADDR_CLKS_QUAD = 6'h06;
	localparam logic [5:0] PARAM_DUMMY_CLKS = 6'h08;
	localparam logic [5:0] UNIQUE_DUMMY_CLKS = 6'h20;
	localparam logic [4:0] WRR_LEN_SHORT = 5'h08;
	localparam logic [4:0] WRR_LEN_LONG = 5'h10;
	localparam int UID_BYTES = 8;
	////////////////////////////////////////////////////////////////
	// self-timed register write
	localparam int T_WRR_NS = 200000;
	localparam int CORE_PERIOD_NS = 10;
	localparam int WRR_CYCLES = T_WRR_NS / CORE_PERIOD_NS;
	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		PH_CMD,
		PH_ADDR,
		PH_DUMMY,
		PH_DATA,
		PH_OUT,
		PH_IGNORE
	} fidc_phase_t;
	typedef enum logic [2:0] {
		SRC_IDENT,
		SRC_PARAM,
		SRC_UNIQUE,
		SRC_ST1,
		SRC_ST2,
		SRC_CFG1
	} fidc_src_t;
endpackage

// >>> core/fidc_core.sv
`timescale 1ns/100ps
// Functional notes
// - quad ident opcode accepted only while quad instruction mode is on.
// - quad ident returns maker byte, two device bytes, extended id, info space.
// - output past ident space undefined; chip select high stops driving.
// - param read takes opcode, 24-bit address, eight dummies, data from falling edge.
// - param bytes go out most significant bit first.
// - param output starts at the supplied address.
// - in quad mode command, address, data and answers use all four lines.
// - unique number read: 32 dummy clocks, then eight bytes.
// - io lines ignored during unique number dummies.
// - unique output past eighth byte undefined; chip select high ends it.
// - status1 read works at any time, even while busy.
// - status byte repeats every eight bits, freshly sampled each time.
// - status2 read on serial line only; not in quad mode.
// - config1 read repeats; not available in quad mode.
// - register write needs the write enable latch set.
// - eight data bits write status1, sixteen write both, else discarded.
// - write starts at chip select rise, busy flag set, then clears with latch.
// - failed write sets program or erase error flag.
// - protect destination select steers block protect bits volatile or nonvolatile.
// - register write sets or clears the protect lock bit.
// - lock bit zero: writes accepted with latch set, whatever the protect pin.
// - lock set and protect pin low: writes silently rejected.
// - quad enable in config1 disables pin write protection.
module fidc_core #(
	parameter logic [63:0] IDENT_TABLE = 64'h5A12_3456_5152_5900, // arbitrary
	parameter int IDENT_LEN = 8,
	parameter logic [127:0] PARAM_TABLE = 128'h5346_4450_0001_00FF_0000_0000_0000_0000,
	parameter int PARAM_LEN = 16,
	parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // arbitrary
	parameter int WRR_CYCLES = fidc_pkg::WRR_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe_n,
	input wire logic i_wp_n,
	input wire logic i_quad_instruction_mode,
	input wire logic i_protect_dest_select,
	input wire logic [7:0] i_status2,
	input wire logic [1:0] i_fail_inject,
	output logic [7:0] o_status1,
	output logic [7:0] o_status1_nv,
	output logic [7:0] o_config1
);
	localparam int TW = $clog2(WRR_CYCLES + 1);

	typedef struct packed {
		fidc_pkg::fidc_phase_t ph;
		fidc_pkg::fidc_src_t src;
		logic [7:0] cmd;
		logic cmd_done;
		logic [5:0] cnt;
		logic [23:0] acc;
		logic [23:0] idx;
		logic [2:0] oc;
		logic [7:0] ob;
		logic [15:0] dat;
		logic [4:0] dcnt;
		logic [24:0] s1;
		logic [24:0] s2;
		logic [24:0] s3;
		logic [24:0] st;
		logic [3:0] oe_pre;
		logic [3:0] io_pre;
	} fidc_link_t;

	typedef struct packed {
		logic [2:0] cs_sync;
		logic cs_st;
		logic [2:0] wp_sync;
		logic wp_st;
		logic [7:0] st1;
		logic [7:0] st1nv;
		logic [7:0] cf1;
		logic len16;
		logic [15:0] wdat;
		logic [TW-1:0] tmr;
	} fidc_ctl_t;

	fidc_link_t l_q;
	fidc_link_t l_d;
	fidc_ctl_t c_q;
	fidc_ctl_t c_d;
	logic fresh_q;
	logic [3:0] oe_q;
	logic [3:0] io_q;
	logic quad;
	logic [2:0] nb;
	logic [7:0] op;
	logic [7:0] cur;
	logic [3:0] sum;
	logic [24:0] sync_in;
	logic rise;
	logic locked;
	logic len_ok;
	logic wrr_req;
	logic wrr_ok;
	logic write_enable_cmd_ok;

	////////////////////////////////////////////////////////////////
	// byte source for answers; one fetch per byte keeps status fresh
	function automatic logic [7:0] fetch(input fidc_pkg::fidc_src_t s,
			input logic [23:0] i, input logic [24:0] v);
		logic [7:0] b;
		b = 8'h00;
		case (s)
			fidc_pkg::SRC_IDENT: begin
				if (i < 24'(IDENT_LEN))
					b = IDENT_TABLE[8*(IDENT_LEN-1-int'(i)) +: 8];
			end
			fidc_pkg::SRC_PARAM: begin
				if (i < 24'(PARAM_LEN))
					b = PARAM_TABLE[8*(PARAM_LEN-1-int'(i)) +: 8];
			end
			fidc_pkg::SRC_UNIQUE: begin
				if (i < 24'(fidc_pkg::UID_BYTES))
					b = UNIQUE_ID[8*(fidc_pkg::UID_BYTES-1-int'(i)) +: 8];
			end
			fidc_pkg::SRC_ST1: b = v[7:0];
			fidc_pkg::SRC_CFG1: b = v[15:8];
			fidc_pkg::SRC_ST2: b = v[23:16];
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	////////////////////////////////////////////////////////////////
	// link side, serial clock
	// frame start flag: set while deselected, so no clock is needed to end a frame
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n)
			fresh_q <= 1'b1;
		else
			fresh_q <= 1'b0;
	end

	assign sync_in = {i_quad_instruction_mode, i_status2, c_q.cf1, c_q.st1};

	always_comb begin
		l_d = l_q;
		quad = l_q.st[24];
		nb = quad ? 3'd4 : 3'd1;
		op = 8'h00;
		cur = 8'h00;
		sum = 4'h0;
		l_d.s1 = sync_in;
		l_d.s2 = l_q.s1;
		l_d.s3 = l_q.s2;
		l_d.st = (l_q.s2 & l_q.s3) | (l_q.st & (l_q.s2 ^ l_q.s3));
		l_d.oe_pre = 4'h0;
		l_d.io_pre = 4'h0;
		if (fresh_q) begin
			l_d.ph = fidc_pkg::PH_CMD;
			l_d.cmd_done = 1'b0;
			l_d.cnt = 6'h00;
			l_d.acc = 24'h00_0000;
			l_d.dcnt = 5'h00;
			l_d.dat = 16'h0000;
		end
		case (l_d.ph)
			fidc_pkg::PH_CMD: begin
				op = quad ? {l_d.acc[3:0], i_io} : {l_d.acc[6:0], i_io[0]};
				l_d.acc = {16'h0000, op};
				l_d.cnt = l_d.cnt + 6'h01;
				if (l_d.cnt == (quad ? fidc_pkg::OP_CLKS_QUAD : fidc_pkg::OP_CLKS_SINGLE)) begin
					l_d.cmd = op;
					l_d.cmd_done = 1'b1;
					l_d.cnt = 6'h00;
					l_d.acc = 24'h00_0000;
					l_d.idx = 24'h00_0000;
					l_d.oc = 3'd0;
					l_d.ph = fidc_pkg::PH_OUT;
					case (op)
						fidc_pkg::OP_QUAD_IDENT: begin
							l_d.src = fidc_pkg::SRC_IDENT;
							if (!quad)
								l_d.ph = fidc_pkg::PH_IGNORE;
						end
						fidc_pkg::OP_PARAM: begin
							l_d.src = fidc_pkg::SRC_PARAM;
							l_d.ph = fidc_pkg::PH_ADDR;
						end
						fidc_pkg::OP_UNIQUE: begin
							l_d.src = fidc_pkg::SRC_UNIQUE;
							l_d.ph = fidc_pkg::PH_DUMMY;
						end
						fidc_pkg::OP_STATUS1: l_d.src = fidc_pkg::SRC_ST1;
						fidc_pkg::OP_STATUS2: begin
							l_d.src = fidc_pkg::SRC_ST2;
							if (quad)
								l_d.ph = fidc_pkg::PH_IGNORE;
						end
						fidc_pkg::OP_CONFIG1: begin
							l_d.src = fidc_pkg::SRC_CFG1;
							if (quad)
								l_d.ph = fidc_pkg::PH_IGNORE;
						end
						fidc_pkg::OP_REG_WRITE,
						fidc_pkg::OP_WRITE_ENABLE: l_d.ph = fidc_pkg::PH_DATA;
						default: l_d.ph = fidc_pkg::PH_IGNORE;
					endcase
				end
			end
			fidc_pkg::PH_ADDR: begin
				l_d.acc = quad ? {l_d.acc[19:0], i_io} : {l_d.acc[22:0], i_io[0]};
				l_d.cnt = l_d.cnt + 6'h01;
				if (l_d.cnt == (quad ? fidc_pkg::ADDR_CLKS_QUAD : fidc_pkg::ADDR_CLKS_SINGLE)) begin
					l_d.idx = l_d.acc;
					l_d.cnt = 6'h00;
					l_d.ph = fidc_pkg::PH_DUMMY;
				end
			end
			fidc_pkg::PH_DUMMY: begin
				// io values not looked at here
				l_d.cnt = l_d.cnt + 6'h01;
				if (l_d.cnt == (l_d.src == fidc_pkg::SRC_PARAM ?
						fidc_pkg::PARAM_DUMMY_CLKS : fidc_pkg::UNIQUE_DUMMY_CLKS)) begin
					l_d.cnt = 6'h00;
					l_d.oc = 3'd0;
					l_d.ph = fidc_pkg::PH_OUT;
				end
			end
			fidc_pkg::PH_DATA: begin
				if (l_d.dcnt < fidc_pkg::WRR_LEN_LONG)
					l_d.dat = quad ? {l_d.dat[11:0], i_io} : {l_d.dat[14:0], i_io[0]};
				// counts one step past sixteen, then sticks: any such length is bad
				if (l_d.dcnt <= fidc_pkg::WRR_LEN_LONG)
					l_d.dcnt = l_d.dcnt + 5'(nb);
			end
			default: begin
			end
		endcase
		if (l_d.ph == fidc_pkg::PH_OUT) begin
			cur = (l_d.oc == 3'd0) ? fetch(l_d.src, l_d.idx, l_q.st) : l_d.ob;
			l_d.ob = cur;
			l_d.oe_pre = quad ? 4'hF : 4'h2;
			if (quad)
				l_d.io_pre = (l_d.oc == 3'd0) ? cur[7:4] : cur[3:0];
			else
				l_d.io_pre = {2'b00, cur[3'd7 - l_d.oc], 1'b0};
			sum = {1'b0, l_d.oc} + {1'b0, nb};
			l_d.oc = sum[2:0];
			if (sum[3])
				l_d.idx = l_d.idx + 24'h00_0001;
		end
	end

	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			l_q <= '{ph: fidc_pkg::PH_IGNORE, src: fidc_pkg::SRC_ST1,
				st: {1'b0, 8'h00, fidc_pkg::CF1_RST, fidc_pkg::ST1_RST}, default: '0};
		end else begin
			l_q <= l_d;
		end
	end

	// answers change on the falling edge; fresh_q blanks a mode 3 first edge
	// chip select high clears the enables, so no frame opens with stale drive
	always_ff @(negedge i_sck or negedge i_rst_n or posedge i_cs_n) begin
		if (!i_rst_n || i_cs_n) begin
			oe_q <= 4'h0;
			io_q <= 4'h0;
		end else begin
			oe_q <= l_q.oe_pre & {4{~fresh_q}};
			io_q <= l_q.io_pre;
		end
	end

	assign o_io = io_q;
	assign o_io_oe_n = ~oe_q | {4{i_cs_n}};

	////////////////////////////////////////////////////////////////
	// core side; link fields are quiet while deselected, read only then
	always_comb begin
		c_d = c_q;
		c_d.cs_sync = {c_q.cs_sync[1:0], i_cs_n};
		c_d.wp_sync = {c_q.wp_sync[1:0], i_wp_n};
		if (c_q.cs_sync[1] == c_q.cs_sync[2])
			c_d.cs_st = c_q.cs_sync[1];
		if (c_q.wp_sync[1] == c_q.wp_sync[2])
			c_d.wp_st = c_q.wp_sync[1];
		rise = (c_q.cs_sync[1] == c_q.cs_sync[2]) & c_q.cs_sync[1] & ~c_q.cs_st;
		locked = c_q.st1[fidc_pkg::ST_LOCK] & ~c_q.wp_st
			& ~c_q.cf1[fidc_pkg::CF_QUAD];
		len_ok = (l_q.dcnt == fidc_pkg::WRR_LEN_SHORT) | (l_q.dcnt == fidc_pkg::WRR_LEN_LONG);
		wrr_req = rise & l_q.cmd_done & (l_q.cmd == fidc_pkg::OP_REG_WRITE);
		wrr_ok = wrr_req & len_ok & c_q.st1[fidc_pkg::ST_WEL]
			& ~c_q.st1[fidc_pkg::ST_WIP] & ~locked;
		write_enable_cmd_ok = rise & l_q.cmd_done & (l_q.cmd == fidc_pkg::OP_WRITE_ENABLE)
			& (l_q.dcnt == 5'h00) & ~c_q.st1[fidc_pkg::ST_WIP];
		if (write_enable_cmd_ok)
			c_d.st1[fidc_pkg::ST_WEL] = 1'b1;
		if (wrr_ok) begin
			c_d.st1[fidc_pkg::ST_WIP] = 1'b1;
			c_d.len16 = (l_q.dcnt == fidc_pkg::WRR_LEN_LONG);
			c_d.wdat = c_d.len16 ? l_q.dat : {l_q.dat[7:0], 8'h00};
			c_d.tmr = TW'(WRR_CYCLES - 1);
		end else if (c_q.st1[fidc_pkg::ST_WIP]) begin
			if (c_q.tmr != '0) begin
				c_d.tmr = c_q.tmr - TW'(1);
			end else begin
				c_d.st1[fidc_pkg::ST_WIP] = 1'b0;
				c_d.st1[fidc_pkg::ST_WEL] = 1'b0;
				if (i_fail_inject != 2'b00) begin
					// a failed write leaves the old values in place
					c_d.st1[fidc_pkg::ST_EERR] = c_q.st1[fidc_pkg::ST_EERR] | i_fail_inject[0];
					c_d.st1[fidc_pkg::ST_PERR] = c_q.st1[fidc_pkg::ST_PERR] | i_fail_inject[1];
				end else begin
					c_d.st1[fidc_pkg::ST_LOCK] = c_q.wdat[8+fidc_pkg::ST_LOCK];
					c_d.st1nv[fidc_pkg::ST_LOCK] = c_q.wdat[8+fidc_pkg::ST_LOCK];
					if (i_protect_dest_select)
						c_d.st1[4:2] = c_q.wdat[12:10];
					else
						c_d.st1nv[4:2] = c_q.wdat[12:10];
					if (c_q.len16)
						c_d.cf1 = c_q.wdat[7:0];
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c_q <= '{cs_sync: 3'b111, cs_st: 1'b1, wp_sync: 3'b111, wp_st: 1'b1,
				st1: fidc_pkg::ST1_RST, st1nv: fidc_pkg::ST1NV_RST,
				cf1: fidc_pkg::CF1_RST, default: '0};
		end else begin
			c_q <= c_d;
		end
	end

	assign o_status1 = c_q.st1;
	assign o_status1_nv = c_q.st1nv;
	assign o_config1 = c_q.cf1;

	////////////////////////////////////////////////////////////////
	// checks
	property p_wrr_start;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wrr_ok |=> o_status1[0] && o_status1[1] ##1 o_status1[0];
	endproperty
	a_wrr_start: assert property (p_wrr_start) else $error("write did not go busy");
	property p_wrr_done;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(o_status1[0]) |-> !o_status1[1];
	endproperty
	a_wrr_done: assert property (p_wrr_done) else $error("latch kept after write");
	property p_need_wel;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wrr_req && !o_status1[1] && !o_status1[0] |=> !o_status1[0] [*2];
	endproperty
	a_need_wel: assert property (p_need_wel) else $error("write ran without latch");
	property p_bad_len;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wrr_req && !len_ok && !o_status1[0] |=> !o_status1[0];
	endproperty
	a_bad_len: assert property (p_bad_len) else $error("bad length write ran");
	property p_locked;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wrr_req && locked && !o_status1[0] |=> !o_status1[0] && $stable(o_status1[6:5]);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write ran");
	property p_quad_unlock;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wrr_req && len_ok && o_status1[1] && !o_status1[0] && o_config1[1] |=> o_status1[0];
	endproperty
	a_quad_unlock: assert property (p_quad_unlock) else $error("quad write refused");
	property p_fail_flag;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(o_status1[0]) && $past(i_fail_inject[1]) |-> o_status1[6];
	endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("program error not flagged");
	property p_dest_nv;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(o_status1[0]) && $past(i_fail_inject) == 2'b00 && !$past(i_protect_dest_select)
			|-> o_status1_nv[4:2] == $past(c_q.wdat[12:10]) && $stable(o_status1[4:2]);
	endproperty
	a_dest_nv: assert property (p_dest_nv) else $error("protect bits misrouted");
	property p_no_ident;
		@(posedge i_sck) disable iff (!i_rst_n)
		l_q.ph == fidc_pkg::PH_IGNORE |-> l_q.oe_pre == 4'h0 ##1 l_q.oe_pre == 4'h0;
	endproperty
	a_no_ident: assert property (p_no_ident) else $error("ignored frame drove io");
	property p_dummy_quiet;
		@(posedge i_sck) disable iff (!i_rst_n)
		l_q.ph == fidc_pkg::PH_DUMMY && !fresh_q |-> l_q.oe_pre == 4'h0;
	endproperty
	a_dummy_quiet: assert property (p_dummy_quiet) else $error("drive during dummies");
endmodule

// >>> tb/fidc_host_model.sv
`timescale 1ns/100ps
module fidc_host_model (
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe_n,
	input wire logic [3:0] i_line,
	input wire logic [3:0] i_dev_oe_n
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
		o_io_oe_n = 4'hF;
	end
	////////////////////////////////////////
	// sck only runs inside a frame; pins released after each rise
	task automatic xfer(input bit quad, input logic [63:0] tx, input int nb, input int dum,
		input int nr, output logic [63:0] rx, output bit drove);
		int w;
		int p;
		w = quad ? 4 : 1;
		rx = '0;
		drove = 1'b0;
		o_cs_n = 1'b0;
		for (int c = 0; c < nb / w + dum; c++) begin
			p = nb - w * c;
			o_io_oe_n = quad ? 4'h0 : 4'hE;
			if (p > 0) begin
				o_io = quad ? tx[p - 1 -: 4] : {3'b000, tx[p - 1]};
			end else begin
				o_io = {4{c[0]}}; // toggles, must be ignored
			end
			#6 o_sck = 1'b1;
			#1 o_io_oe_n = 4'hF;
			#5 o_sck = 1'b0;
		end
		for (int c = 0; c < nr; c += w) begin
			#6 o_sck = 1'b1;
			rx = quad ? {rx[59:0], i_line} : {rx[62:0], i_line[1]};
			drove |= (i_dev_oe_n !== 4'hF);
			#6 o_sck = 1'b0;
		end
		#3 o_cs_n = 1'b1; // right after the last bit
		#150;
	endtask
endmodule

// >>> tb/fidc_core_test.sv
`timescale 1ns/100ps
module fidc_core_test;
	typedef struct {
		bit q;
		logic [7:0] op;
		int ab;
		logic [23:0] ad;
		int dm;
		int nr;
		logic [63:0] ex;
		bit dr;
	} fidc_row_t;
	localparam logic [63:0] IDT = 64'h1122_3344_5566_7788; // arbitrary
	localparam logic [127:0] PT = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
	localparam logic [63:0] UID = 64'hFEDC_BA98_7654_3210; // arbitrary
	logic clk = 1'b0;
	logic rst_n, wp_n, qmode, dsel, sck, cs_n;
	logic [7:0] st2, st1, st1nv, cfg1;
	logic [1:0] fail;
	logic [3:0] h_io, h_oe_n, d_io, d_oe_n, line;
	logic [63:0] rx;
	bit dr;
	bit cq;
	int n_fail, n_compared;
	fidc_row_t rows[13];
	always #5 clk = ~clk;
	// pull-ups where nobody drives
	assign line = (~d_oe_n & d_io) | (d_oe_n & ~h_oe_n & h_io) | (d_oe_n & h_oe_n);
	fidc_core #(.IDENT_TABLE(IDT), .IDENT_LEN(8), .PARAM_TABLE(PT), .PARAM_LEN(16),
		.UNIQUE_ID(UID), .WRR_CYCLES(40)) dut_u (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_io(line),
		.o_io(d_io), .o_io_oe_n(d_oe_n), .i_wp_n(wp_n), .i_quad_instruction_mode(qmode),
		.i_protect_dest_select(dsel), .i_status2(st2), .i_fail_inject(fail),
		.o_status1(st1), .o_status1_nv(st1nv), .o_config1(cfg1));
	fidc_host_model host_u (.o_sck(sck), .o_cs_n(cs_n), .o_io(h_io), .o_io_oe_n(h_oe_n),
		.i_line(line), .i_dev_oe_n(d_oe_n));
	////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] ex, input string m);
		n_compared++;
		if (got !== ex) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, ex);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// mode change needs a few sck edges, so a harmless frame follows
	task automatic set_quad(input bit q);
		@(negedge clk);
		qmode = q;
		cq = q;
		host_u.xfer(1'b0, 64'h00, 8, 0, 0, rx, dr);
	endtask
	task automatic write_enable_cmd();
		host_u.xfer(1'b0, 64'h06, 8, 0, 0, rx, dr);
	endtask
	task automatic register_write_cmd(input logic [15:0] d, input int n);
		host_u.xfer(1'b0, (64'h01 << n) | {48'h0, d}, 8 + n, 0, 0, rx, dr);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (st1[0] !== 1'b0 && k < 200) begin
			@(negedge clk);
			k++;
		end
		chk(k < 200, 1, "busy stuck");
	endtask
	////////////////////////////////////////
	initial begin
		#200us;
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		qmode = 1'b0;
		dsel = 1'b1;
		st2 = 8'hA5;
		fail = 2'b00;
		cq = 1'b0;
		n_fail = 0;
		n_compared = 0;
		rows[0] = '{0, 8'h05, 0, 0, 0, 16, 64'h0, 1};
		rows[1] = '{0, 8'h35, 0, 0, 0, 8, 64'h0, 1};
		rows[2] = '{0, 8'h07, 0, 0, 0, 16, 64'hA5A5, 1};
		rows[3] = '{0, 8'h5A, 24, 0, 8, 32, 64'h0011_2233, 1};
		rows[4] = '{0, 8'h5A, 24, 5, 8, 16, 64'h5566, 1};
		rows[5] = '{0, 8'h4C, 0, 0, 32, 64, UID, 1};
		rows[6] = '{0, 8'hAF, 0, 0, 0, 16, 64'hFFFF, 0};
		rows[7] = '{1, 8'hAF, 0, 0, 0, 64, IDT, 1};
		rows[8] = '{1, 8'h5A, 24, 3, 8, 16, 64'h3344, 1};
		rows[9] = '{1, 8'h4C, 0, 0, 32, 64, UID, 1};
		rows[10] = '{1, 8'h05, 0, 0, 0, 8, 64'h0, 1};
		rows[11] = '{1, 8'h07, 0, 0, 0, 8, 64'hFF, 0};
		rows[12] = '{1, 8'h35, 0, 0, 0, 8, 64'hFF, 0};
		settle(3);
		rst_n = 1'b1;
		settle(3);
		foreach (rows[i]) begin
			if (rows[i].q != cq) set_quad(rows[i].q);
			host_u.xfer(rows[i].q, {32'h0, rows[i].op, rows[i].ad} >> (24 - rows[i].ab),
				8 + rows[i].ab, rows[i].dm, rows[i].nr, rx, dr);
			chk(rx, rows[i].ex, "read data");
			chk(dr, rows[i].dr, "drive presence");
			chk(d_oe_n, 4'hF, "released after frame");
			$display("row %0d done", i);
		end
		set_quad(1'b0);
		// no latch: write dropped
		register_write_cmd(16'h001C, 8);
		settle(60);
		chk(st1, 8'h00, "write without latch");
		@(negedge clk);
		dsel = 1'b1;
		wp_n = 1'b0;
		write_enable_cmd();
		chk(st1, 8'h02, "latch set");
		register_write_cmd(16'h009C, 8);
		host_u.xfer(1'b0, 64'h05, 8, 0, 64, rx, dr);
		chk(rx[63:56], 8'h03, "status while busy");
		chk(rx[7:0], 8'h9C, "status refreshed");
		wait_idle();
		chk(st1, 8'h9C, "short write volatile");
		chk(st1nv, 8'h80, "lock in nonvolatile");
		$display("basic write done");
		write_enable_cmd();
		register_write_cmd(16'h0080, 8);
		settle(60);
		chk(st1, 8'h9E, "locked write rejected");
		@(negedge clk);
		wp_n = 1'b1;
		register_write_cmd(16'h8002, 16);
		wait_idle();
		chk(st1, 8'h80, "long write status");
		chk(cfg1, 8'h02, "long write config");
		@(negedge clk);
		wp_n = 1'b0;
		write_enable_cmd();
		register_write_cmd(16'h0084, 8);
		wait_idle();
		chk(st1, 8'h84, "quad enable lifts pin lock");
		@(negedge clk);
		dsel = 1'b0;
		write_enable_cmd();
		register_write_cmd(16'h0088, 8);
		wait_idle();
		chk(st1, 8'h84, "volatile protect kept");
		chk(st1nv, 8'h88, "nonvolatile protect");
		write_enable_cmd();
		register_write_cmd(16'h0FFF, 12);
		settle(60);
		chk(st1 & 8'hFD, 8'h84, "odd length discarded");
		chk(cfg1, 8'h02, "config untouched");
		$display("protection done");
		@(negedge clk);
		fail = 2'b10;
		write_enable_cmd();
		register_write_cmd(16'h0080, 8);
		wait_idle();
		chk(st1, 8'hC4, "program error flag");
		@(negedge clk);
		fail = 2'b00;
		rst_n = 1'b0;
		settle(3);
		chk({st1, st1nv, cfg1}, 24'h0, "reset values");
		rst_n = 1'b1;
		settle(3);
		host_u.xfer(1'b0, 64'h05, 8, 0, 8, rx, dr);
		chk(rx, 64'h0, "status after reset");
		chk(d_oe_n, 4'hF, "released after reset frame");
		$display("error and reset done");
		end_sim();
	end
endmodule
